// >>> inc/dets_regs.svh
// register map, field positions, reset values and timing of the sequencer
// What this block does
// - paired-edge records hold start, stop, one count
// - 50 ns recovery after stop before next start
// - result is stop minus start, start count
// - arming gates only the start capture
// - period stops on next same-polarity edge
// - pulse width stops on next opposite edge
// - one-channel interval uses separate edge polarities
// - rise/fall use one edge, two thresholds
// - two-channel interval, either direction, both units
// - stop-arm delay picks the stop edge, in two-channel interval only
// - spacing between measurements 50 ns to 400 days
// - averages chain end time into next start
// - event counter spans 1.8e16 events
// - continuous interval spans 50 ns to 400 days
// - error mode reports deviation from expected time
// - every record carries absolute time and count
// - channel A and B behave identically
// - prescaler divides edges by sixteen when selected, in continuous and error modes only
// - short periods and widths down to resolution
// - events keep counting during recovery
// - single-edge records hold one time, one count
`ifndef DETS_REGS_SVH
`define DETS_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define DETS_CTRL_OFS        8'h00
`define DETS_STOP_DELAY_OFS  8'h04
`define DETS_REF_PERIOD_OFS  8'h08
`define DETS_STATUS_OFS      8'h0C
`define DETS_REC_TOTAL_OFS   8'h10
`define DETS_RESULT_LO_OFS   8'h14
`define DETS_RESULT_HI_OFS   8'h18

// ****************************************************************
// control fields
// ****************************************************************
`define DETS_CTRL_EN         0
`define DETS_CTRL_MODE_LO    1
`define DETS_CTRL_MODE_HI    4
`define DETS_CTRL_CHAN       5
`define DETS_CTRL_START_POL  6
`define DETS_CTRL_STOP_POL   7
`define DETS_CTRL_PRESC      8

// ****************************************************************
// reset values and timing
// ****************************************************************
`define DETS_CTRL_RST        32'h0000_00C0
`define DETS_ZERO_RST        32'h0000_0000
`define DETS_RECOV_NS        50
`define DETS_CLK_MHZ         100
`define DETS_PRESC_LAST      4'hF

`endif

// >>> inc/dets_pkg.sv
// types shared by the timetag sequencer
package dets_pkg;
    typedef enum logic [3:0] {
        md_frequency_average     = 4'h0,
        md_period_average        = 4'h1,
        md_continuous_interval_mode = 4'h2,
        md_timing_error_mode     = 4'h3,
        md_period                = 4'h4,
        md_pulse_width_mode      = 4'h5,
        md_one_channel_interval_mode = 4'h6,
        md_rise                  = 4'h7,
        md_fall                  = 4'h8,
        md_two_channel_interval_mode = 4'h9
    } dets_mode_type;

    typedef enum logic [1:0] {
        st_idle    = 2'h0,
        st_wait    = 2'h1,
        st_recover = 2'h3
    } dets_state_type;
endpackage : dets_pkg

// >>> verilog/dets_sequencer.sv
// timetag sequencer with ahb-lite register slave
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "dets_regs.svh"

module dets_sequencer
    import dets_pkg::*;
#(
    parameter int TIME_W = 56,
    parameter int CNT_W  = 56
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // comparator channels, index 0 is A and 1 is B
    input  wire logic [1:0]        ch_main,
    input  wire logic [1:0]        ch_upper,
    input  wire logic              start_arm,
    // record stream to measurement memory
    output logic                   rec_valid,
    output logic [TIME_W-1:0]      rec_start_time,
    output logic [TIME_W-1:0]      rec_stop_time,
    output logic [TIME_W-1:0]      rec_result,
    output logic [CNT_W-1:0]       rec_count,
    output logic                   busy
);

    localparam int RECOV_CYC =
        (`DETS_RECOV_NS * `DETS_CLK_MHZ + 999) / 1000;

    // 400 days of 10 ns ticks needs 52 bits, 1.8e16 events needs 54
    if (TIME_W < 52 || TIME_W > 64 || CNT_W < 54 || CNT_W > 64) begin : g_w
        $error("dets_sequencer: unsupported counter widths");
    end
    if (RECOV_CYC < 2 || RECOV_CYC > 8) begin : g_rc
        $error("dets_sequencer: recovery count out of range");
    end

    typedef struct packed {
        logic                  hreadyout;
        logic                  hresp;
        logic [31:0]           hrdata;
        logic                  wr_pend;
        logic [7:0]            wr_addr;
        logic [31:0]           ctrl;
        logic [31:0]           stop_delay;
        logic [31:0]           ref_period;
        logic [31:0]           rec_total;
        logic [TIME_W-1:0]     last_result;
        logic [TIME_W-1:0]     tbase;
        logic [CNT_W-1:0]      events;
        logic [3:0]            presc;
        logic [1:0]            prev_main;
        logic [1:0]            prev_upper;
        dets_state_type        state;
        logic [2:0]            recov;
        logic [31:0]           dly;
        logic [TIME_W-1:0]     t_start;
        logic [CNT_W-1:0]      e_start;
        logic                  have_prev;
        logic [TIME_W-1:0]     last_t;
        logic [TIME_W-1:0]     expect_t;
        logic                  rec_valid;
        logic [TIME_W-1:0]     rec_start_time;
        logic [TIME_W-1:0]     rec_stop_time;
        logic [TIME_W-1:0]     rec_result;
        logic [CNT_W-1:0]      rec_count;
        logic                  busy;
    } dets_state_struct_type;

    dets_state_struct_type s;
    dets_state_struct_type next_s;

    // ****************************************************************
    // edge detection and start/stop selection
    // ****************************************************************
    logic              sel;
    logic              oth;
    logic              en;
    dets_mode_type     mode;
    logic              single_grp;
    logic              dual_grp;
    logic              m_rise;
    logic              m_fall;
    logic              u_rise;
    logic              u_fall;
    logic              o_rise;
    logic              o_fall;
    logic              ev_edge;
    logic              ev_tick;
    logic              start_hit;
    logic              stop_hit;
    logic              same_edge;
    logic              accept;
    logic [CNT_W-1:0]  ev_now;
    logic [63:0]       res64;

    function automatic logic pick(input logic pol, input logic r,
                                  input logic f);
        return pol ? r : f;
    endfunction : pick

    assign en         = s.ctrl[`DETS_CTRL_EN];
    assign mode       =
        dets_mode_type'(s.ctrl[`DETS_CTRL_MODE_HI:`DETS_CTRL_MODE_LO]);
    assign sel        = s.ctrl[`DETS_CTRL_CHAN];
    assign oth        = ~sel;
    assign single_grp = (mode <= md_timing_error_mode);
    assign dual_grp   = (mode == md_two_channel_interval_mode);
    assign accept     = hsel & htrans[1] & hready;
    assign res64      = 64'(s.last_result);

    always_comb begin
        // one indexed path per channel keeps A and B symmetric
        m_rise  = ch_main[sel] & ~s.prev_main[sel];
        m_fall  = ~ch_main[sel] & s.prev_main[sel];
        u_rise  = ch_upper[sel] & ~s.prev_upper[sel];
        u_fall  = ~ch_upper[sel] & s.prev_upper[sel];
        o_rise  = ch_main[oth] & ~s.prev_main[oth];
        o_fall  = ~ch_main[oth] & s.prev_main[oth];
        ev_edge = pick(s.ctrl[`DETS_CTRL_START_POL], m_rise, m_fall);
        // divide by sixteen only for continuous and error modes
        if (s.ctrl[`DETS_CTRL_PRESC] &&
            (mode == md_continuous_interval_mode ||
             mode == md_timing_error_mode))
            ev_tick = ev_edge & (s.presc == `DETS_PRESC_LAST);
        else
            ev_tick = ev_edge;
        ev_now    = s.events + CNT_W'(ev_tick);
        same_edge = 1'b0;
        case (mode)
            md_period: begin
                start_hit = ev_edge;
                stop_hit  = ev_edge;
            end
            md_pulse_width_mode: begin
                start_hit = ev_edge;
                stop_hit  = pick(~s.ctrl[`DETS_CTRL_START_POL],
                                 m_rise, m_fall);
            end
            md_one_channel_interval_mode: begin
                start_hit = ev_edge;
                stop_hit  = pick(s.ctrl[`DETS_CTRL_STOP_POL],
                                 m_rise, m_fall);
            end
            md_rise: begin
                start_hit = m_rise;
                stop_hit  = u_rise;
                same_edge = 1'b1;
            end
            md_fall: begin
                start_hit = u_fall;
                stop_hit  = m_fall;
                same_edge = 1'b1;
            end
            md_two_channel_interval_mode: begin
                start_hit = ev_edge;
                stop_hit  = pick(s.ctrl[`DETS_CTRL_STOP_POL],
                                 o_rise, o_fall);
            end
            default: begin
                start_hit = ev_tick;
                stop_hit  = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_s            = s;
        next_s.rec_valid  = 1'b0;
        next_s.hreadyout  = 1'b1;
        next_s.hresp      = 1'b0;
        // absolute timebase spans 400 days between captures
        next_s.tbase      = s.tbase + 1'b1;
        next_s.prev_main  = ch_main;
        next_s.prev_upper = ch_upper;
        // counter never pauses, recovery included
        next_s.events     = ev_now;
        if (ev_edge)
            next_s.presc = s.presc + 1'b1;

        // data phase of a write
        if (s.wr_pend) begin
            case (s.wr_addr)
                `DETS_CTRL_OFS:       next_s.ctrl       = hwdata;
                `DETS_STOP_DELAY_OFS: next_s.stop_delay = hwdata;
                `DETS_REF_PERIOD_OFS: next_s.ref_period = hwdata;
                default: ;
            endcase
        end
        next_s.wr_pend = accept & hwrite;
        next_s.wr_addr = haddr[7:0];

        case (s.state)
            st_idle: begin
                if (!en) begin
                    next_s.have_prev = 1'b0;
                end else if (single_grp) begin
                    // one unit: one time and one count per record
                    if (start_hit && start_arm) begin
                        next_s.rec_valid      = 1'b1;
                        next_s.rec_stop_time  = s.tbase;
                        next_s.rec_count      = ev_now;
                        // previous end is this start, no dead time
                        next_s.rec_start_time =
                            s.have_prev ? s.last_t : s.tbase;
                        next_s.rec_result =
                            s.tbase - (s.have_prev ? s.last_t : s.tbase);
                        if (mode == md_timing_error_mode) begin
                            next_s.rec_result = s.tbase -
                                (s.have_prev ? s.expect_t : s.tbase);
                            next_s.expect_t =
                                (s.have_prev ? s.expect_t : s.tbase) +
                                TIME_W'(s.ref_period);
                        end
                        next_s.last_t    = s.tbase;
                        next_s.have_prev = 1'b1;
                        next_s.state     = st_recover;
                        next_s.recov     = 3'(RECOV_CYC - 1);
                    end
                end else if (start_hit && start_arm) begin
                    next_s.t_start = s.tbase;
                    next_s.e_start = ev_now;
                    next_s.dly     = dual_grp ? s.stop_delay : 32'h0;
                    if (same_edge && stop_hit) begin
                        next_s.rec_valid      = 1'b1;
                        next_s.rec_start_time = s.tbase;
                        next_s.rec_stop_time  = s.tbase;
                        next_s.rec_result     = '0;
                        next_s.rec_count      = ev_now;
                        next_s.state          = st_recover;
                        next_s.recov          = 3'(RECOV_CYC - 1);
                    end else begin
                        next_s.state = st_wait;
                    end
                end
            end
            st_wait: begin
                // later starts are ignored while a stop is pending
                if (!en) begin
                    next_s.state = st_idle;
                end else if (s.dly != 32'h0) begin
                    next_s.dly = s.dly - 1'b1;
                end else if (stop_hit) begin
                    next_s.rec_valid      = 1'b1;
                    next_s.rec_start_time = s.t_start;
                    next_s.rec_stop_time  = s.tbase;
                    next_s.rec_result     = s.tbase - s.t_start;
                    next_s.rec_count      = s.e_start;
                    next_s.state          = st_recover;
                    next_s.recov          = 3'(RECOV_CYC - 1);
                end
            end
            st_recover: begin
                if (s.recov <= 3'h1)
                    next_s.state = st_idle;
                else
                    next_s.recov = s.recov - 1'b1;
            end
            default: next_s.state = st_idle;
        endcase

        next_s.busy = (next_s.state != st_idle);

        if (next_s.rec_valid) begin
            next_s.rec_total   = s.rec_total + 1'b1;
            next_s.last_result = next_s.rec_result;
        end

        // read data is taken in the address phase, after any write
        if (accept && !hwrite) begin
            case (haddr[7:0])
                `DETS_CTRL_OFS:       next_s.hrdata = next_s.ctrl;
                `DETS_STOP_DELAY_OFS: next_s.hrdata = next_s.stop_delay;
                `DETS_REF_PERIOD_OFS: next_s.hrdata = next_s.ref_period;
                `DETS_STATUS_OFS:
                    next_s.hrdata = {29'h0, s.have_prev, s.state};
                `DETS_REC_TOTAL_OFS:  next_s.hrdata = s.rec_total;
                `DETS_RESULT_LO_OFS:  next_s.hrdata = res64[31:0];
                `DETS_RESULT_HI_OFS:  next_s.hrdata = res64[63:32];
                default:              next_s.hrdata = 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            s            <= '0;
            s.hreadyout  <= 1'b1;
            s.ctrl       <= `DETS_CTRL_RST;
            s.stop_delay <= `DETS_ZERO_RST;
            s.ref_period <= `DETS_ZERO_RST;
            s.state      <= st_idle;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout      = s.hreadyout;
    assign hresp          = s.hresp;
    assign hrdata         = s.hrdata;
    assign rec_valid      = s.rec_valid;
    assign rec_start_time = s.rec_start_time;
    assign rec_stop_time  = s.rec_stop_time;
    assign rec_result     = s.rec_result;
    assign rec_count      = s.rec_count;
    assign busy           = s.busy;

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_recovery;
        @(posedge clk) disable iff (srst)
        rec_valid |=> !rec_valid [*4];
    endproperty
    a_recovery: assert property (p_recovery)
        else $error("record taken inside recovery");

    property p_difference;
        @(posedge clk) disable iff (srst)
        (rec_valid && !single_grp) |->
            rec_result == rec_stop_time - rec_start_time;
    endproperty
    a_difference: assert property (p_difference)
        else $error("result is not stop minus start");

    property p_start_count;
        @(posedge clk) disable iff (srst)
        (s.state == st_wait && next_s.state == st_recover && en) |=>
            rec_valid && rec_count == $past(s.e_start);
    endproperty
    a_start_count: assert property (p_start_count)
        else $error("record count is not the start count");

    property p_counting;
        @(posedge clk) disable iff (srst)
        (ev_tick && s.state == st_recover) |=>
            s.events == $past(s.events) + 1'b1;
    endproperty
    a_counting: assert property (p_counting)
        else $error("event lost during recovery");

    property p_hold_start;
        @(posedge clk) disable iff (srst)
        (s.state == st_wait && start_hit && !stop_hit) |=>
            $stable(s.t_start);
    endproperty
    a_hold_start: assert property (p_hold_start)
        else $error("pending start overwritten");

    property p_arm_gate;
        @(posedge clk) disable iff (srst)
        (s.state == st_idle && !start_arm) |=>
            s.state == st_idle && !rec_valid;
    endproperty
    a_arm_gate: assert property (p_arm_gate)
        else $error("capture without start arm");

    property p_stop_delay;
        @(posedge clk) disable iff (srst)
        (s.state == st_wait && s.dly != 32'h0) |=> !rec_valid;
    endproperty
    a_stop_delay: assert property (p_stop_delay)
        else $error("stop taken before stop-arm delay");

    property p_chain;
        @(posedge clk) disable iff (srst)
        (rec_valid && single_grp && $past(s.have_prev)) |->
            rec_start_time == $past(s.last_t);
    endproperty
    a_chain: assert property (p_chain)
        else $error("average record not chained to previous end");

endmodule : dets_sequencer

// >>> dv/dets_chan_model.sv
// comparator channel model driving main and upper threshold levels
`timescale 1ns/10ps

module dets_chan_model (
    // clock
    input  wire logic       clk,
    // comparator outputs, index 0 is A and 1 is B
    output logic [1:0]      ch_main,
    output logic [1:0]      ch_upper
);
    initial begin
        ch_main  = 2'h0;
        ch_upper = 2'h0;
    end

    // new levels right after an edge, held for hold cycles
    task automatic set_lvl(input logic [1:0] m, input logic [1:0] u,
                           input int hold);
        @(posedge clk);
        ch_main  <= m;
        ch_upper <= u;
        repeat (hold - 1) @(posedge clk);
    endtask : set_lvl
endmodule : dets_chan_model

// >>> dv/dual_edge_timetag_sequencer_test.sv
// self-checking bench for the timetag sequencer
`timescale 1ns/10ps
`include "dets_regs.svh"

module dual_edge_timetag_sequencer_test import dets_pkg::*;;
    logic        clk, srst, hsel, hwrite, start_arm;
    logic        hreadyout, hresp, rec_valid, busy;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, ch_main, ch_upper;
    logic [2:0]  hsize;
    logic [55:0] rs, rp, rr, rc, pstop, cstop, pcnt, ccnt;
    int          num_errors, total_checks, n_rec, gap, base;

    dets_sequencer dut_u (.clk(clk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ch_main(ch_main),
        .ch_upper(ch_upper), .start_arm(start_arm), .rec_valid(rec_valid),
        .rec_start_time(rs), .rec_stop_time(rp), .rec_result(rr),
        .rec_count(rc), .busy(busy));
    dets_chan_model chan_u (.clk(clk), .ch_main(ch_main),
        .ch_upper(ch_upper));

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // record monitor keeps the last two stop times and counts
    always @(posedge clk) begin
        gap <= gap + 1;
        if (rec_valid === 1'b1) begin
            if (n_rec > 0) check(64'(gap >= 4), 64'h1);
            gap   <= 0;
            pstop <= cstop;
            cstop <= rp;
            pcnt  <= ccnt;
            ccnt  <= rc;
            n_rec <= n_rec + 1;
        end
    end

    // ****************************************************************
    // bus and stimulus tasks
    // ****************************************************************
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        check(64'(q), 64'(e));
    endtask : rd_chk

    function automatic logic [31:0] cw(dets_mode_type m, logic c, logic sp,
                                       logic tp, logic ps);
        return {23'h0, ps, tp, sp, c, m, 1'b1};
    endfunction : cw

    task automatic cfg(input logic [31:0] v);
        wr(`DETS_CTRL_OFS, 32'h0);
        wr(`DETS_CTRL_OFS, v);
        base = n_rec;
    endtask : cfg

    task automatic lv(input logic [1:0] m, input logic [1:0] u, input int n);
        chan_u.set_lvl(m, u, n);
    endtask : lv

    task automatic expect_rec(input int k, input logic [55:0] res,
                              input logic diff);
        for (int i = 0; i < 200 && n_rec < base + k; i++) @(posedge clk);
        #1;
        check(64'(n_rec), 64'(base + k));
        check(64'(rr), 64'(res));
        if (diff) check(64'(rp - rs), 64'(res));
    endtask : expect_rec

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, num_errors);
    endtask : end_test

    // ****************************************************************
    // clock, watchdog and tests
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end

    initial begin
        {srst, hsel, hwrite, htrans, hsize} = {1'b1, 1'b1, 1'b0, 2'h0, 3'h2};
        {haddr, hwdata, start_arm, n_rec, gap} = {64'h0, 1'b1, 32'h0, 32'h0};
        {num_errors, total_checks, base} = 96'h0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check(64'({busy, rec_valid, hresp}), 64'h0);
        rd_chk(`DETS_CTRL_OFS, `DETS_CTRL_RST);
        rd_chk(`DETS_STATUS_OFS, `DETS_ZERO_RST);
        rd_chk(`DETS_RESULT_HI_OFS, `DETS_ZERO_RST);
        wr(8'h1C, 32'h0000_00FF);
        rd_chk(8'h1C, 32'h0);
        wr(`DETS_STOP_DELAY_OFS, 32'h0000_0123);
        rd_chk(`DETS_STOP_DELAY_OFS, 32'h0000_0123);
        end_test("registers");
        // second rise falls in recovery and is not a start
        cfg(cw(md_pulse_width_mode, 0, 1, 0, 0));
        lv(2'h1, 2'h0, 7); lv(2'h0, 2'h0, 2); lv(2'h1, 2'h0, 7);
        lv(2'h0, 2'h0, 3); lv(2'h1, 2'h0, 4); lv(2'h0, 2'h0, 10);
        expect_rec(2, 56'd4, 1);
        check(64'(ccnt - pcnt), 64'h2);
        base = n_rec;
        start_arm <= 1'b0;
        lv(2'h1, 2'h0, 4); lv(2'h0, 2'h0, 10);
        check(64'(n_rec), 64'(base));
        start_arm <= 1'b1;
        end_test("pulse width");
        cfg(cw(md_period, 1, 1, 1, 0));
        lv(2'h2, 2'h0, 4); lv(2'h0, 2'h0, 5); lv(2'h2, 2'h0, 4);
        lv(2'h0, 2'h0, 10);
        expect_rec(1, 56'd9, 1);
        cfg(cw(md_one_channel_interval_mode, 0, 0, 1, 0));
        lv(2'h1, 2'h0, 5); lv(2'h0, 2'h0, 6); lv(2'h1, 2'h0, 5);
        lv(2'h0, 2'h0, 10);
        expect_rec(1, 56'd6, 1);
        check(64'(busy), 64'h1);
        cfg(cw(md_rise, 0, 1, 1, 0));
        lv(2'h1, 2'h0, 3); lv(2'h1, 2'h1, 5); lv(2'h0, 2'h0, 10);
        expect_rec(1, 56'd3, 1);
        wr(`DETS_CTRL_OFS, 32'h0);
        lv(2'h1, 2'h1, 8);
        cfg(cw(md_fall, 0, 0, 0, 0));
        lv(2'h1, 2'h0, 3); lv(2'h0, 2'h0, 10);
        expect_rec(1, 56'd3, 1);
        end_test("one channel");
        wr(`DETS_STOP_DELAY_OFS, 32'h0);
        cfg(cw(md_two_channel_interval_mode, 0, 1, 1, 0));
        lv(2'h1, 2'h0, 2); lv(2'h0, 2'h0, 2); lv(2'h1, 2'h0, 5);
        lv(2'h3, 2'h0, 5); lv(2'h0, 2'h0, 10);
        expect_rec(1, 56'd9, 1);
        cfg(cw(md_two_channel_interval_mode, 1, 1, 1, 0));
        lv(2'h2, 2'h0, 3); lv(2'h3, 2'h0, 6); lv(2'h0, 2'h0, 10);
        expect_rec(1, 56'd3, 1);
        wr(`DETS_STOP_DELAY_OFS, 32'h6);
        cfg(cw(md_two_channel_interval_mode, 0, 1, 1, 0));
        lv(2'h1, 2'h0, 4); lv(2'h3, 2'h0, 2); lv(2'h1, 2'h0, 4);
        lv(2'h3, 2'h0, 4); lv(2'h0, 2'h0, 10);
        expect_rec(1, 56'd10, 1);
        end_test("two channel");
        for (int m = 0; m < 3; m++) begin
            cfg(cw(dets_mode_type'(m), 0, 1, 1, 0));
            repeat (3) begin
                lv(2'h1, 2'h0, 4); lv(2'h0, 2'h0, 4);
            end
            expect_rec(3, 56'd8, 1);
            check(64'(rs), 64'(pstop));
            check(64'(ccnt - pcnt), 64'h1);
        end
        wr(`DETS_REF_PERIOD_OFS, 32'h8);
        cfg(cw(md_timing_error_mode, 0, 1, 1, 0));
        lv(2'h1, 2'h0, 4); lv(2'h0, 2'h0, 4); lv(2'h1, 2'h0, 4);
        lv(2'h0, 2'h0, 5); lv(2'h1, 2'h0, 4); lv(2'h0, 2'h0, 8);
        expect_rec(3, 56'd1, 0);
        cfg(cw(md_continuous_interval_mode, 0, 1, 1, 1));
        repeat (40) begin
            lv(2'h1, 2'h0, 3); lv(2'h0, 2'h0, 3);
        end
        check(64'(rr), 64'd96);
        check(64'(ccnt - pcnt), 64'h1);
        rd_chk(`DETS_RESULT_LO_OFS, 32'h0000_0060);
        end_test("single edge");
        complete_run();
    end
endmodule : dual_edge_timetag_sequencer_test
